// >>> common/dmbam_pkg.sv
/*
 Package for the data-memory bank address mapper: data address layout,
 access-bank split, region bounds and special register addresses.
 Assumes nothing of its users beyond a SystemVerilog package import.
*/
package dmbam_pkg;
    localparam int DMBAM_DADDR_W = 12;
    localparam int DMBAM_FADDR_W = 8;
    localparam int DMBAM_BANK_W = 4;
    localparam int DMBAM_DATA_W = 8;
    localparam logic [7:0] DMBAM_ACC_SPLIT = 8'h60;
    localparam logic [3:0] DMBAM_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] DMBAM_ACC_HI_BANK = 4'hF;
    localparam logic [11:0] DMBAM_GPR_BASE = 12'h000;
    localparam logic [11:0] DMBAM_SFR_BASE = 12'hF38;
    localparam logic [11:0] DMBAM_SFR_TOP = 12'hFFF;
    localparam logic [11:0] DMBAM_BANK_PTR_ADDR = 12'hFE0;
    localparam logic [11:0] DMBAM_IND0_ADDR = 12'hFEF;
    localparam logic [11:0] DMBAM_IND0_LAST = 12'hFEB;
    localparam logic [11:0] DMBAM_IND1_ADDR = 12'hFE7;
    localparam logic [11:0] DMBAM_IND1_LAST = 12'hFE3;
    localparam logic [11:0] DMBAM_IND2_ADDR = 12'hFDF;
    localparam logic [11:0] DMBAM_IND2_LAST = 12'hFDB;
    localparam logic [7:0] DMBAM_BANK_PTR_RST = 8'h00;
    localparam logic [7:0] DMBAM_ZERO = 8'h00;
    localparam logic [11:0] DMBAM_GPR_TOP_DFLT = 12'h7FF;
endpackage : dmbam_pkg

// >>> verif/dmbam_core_model.sv
/* core decoder model: issues operand accesses and full-address moves.
 assumes the mapper shares its clock. */
`timescale 1ns/10ps
module dmbam_core_model (
    input wire logic ref_clk_i, // clock
    input wire logic [7:0] rdata_i, // operand data
    output logic [7:0] file_addr_o, // file addr
    output logic access_sel_o, // access bit
    output logic full_move_o, // move
    output logic [11:0] move_src_o, // move src
    output logic [11:0] move_dst_o, // move dst
    output logic move_wr_phase_o, // dst beat
    output logic rd_o, // read
    output logic wr_o, // write
    output logic [7:0] wdata_o // data
);
    initial begin
        {file_addr_o, access_sel_o, full_move_o, move_src_o, move_dst_o} = '0;
        {move_wr_phase_o, rd_o, wr_o, wdata_o} = '0;
    end
    // rwa: read, write, access bit; data line scrambled once released
    task automatic op(input logic [2:0] rwa, input logic [7:0] fa, d, output logic [7:0] q);
        @(posedge ref_clk_i);
        {rd_o, wr_o, access_sel_o} <= rwa;
        file_addr_o <= fa;
        wdata_o <= d;
        @(posedge ref_clk_i);
        {rd_o, wr_o} <= 2'h0;
        wdata_o <= ~d;
        #1 q = rdata_i;
    endtask : op
    task automatic mv(input logic [11:0] s, t);
        logic [7:0] q;
        @(posedge ref_clk_i);
        full_move_o <= 1'b1;
        move_src_o <= s;
        move_dst_o <= t;
        op(3'h4, 8'h00, 8'h00, q);
        @(posedge ref_clk_i);
        move_wr_phase_o <= 1'b1;
        op(3'h2, 8'h00, q, q);
        @(posedge ref_clk_i);
        {full_move_o, move_wr_phase_o} <= 2'h0;
    endtask : mv
endmodule : dmbam_core_model

// >>> verif/dmbam_properties.sv
/* port assertions for the address mapper.
 assumes a bind onto dmbam_top, one clock domain. */
`timescale 1ns/10ps
module dmbam_properties (
    input wire logic ref_clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic [7:0] file_addr_i, // file addr
    input wire logic access_sel_i, // access bit
    input wire logic full_move_i, // move
    input wire logic [11:0] move_src_i, // move src
    input wire logic extended_instruction_enable_i, // ext
    input wire logic rd_i, // read
    input wire logic wr_i, // write
    input wire logic [11:0] reg_addr_i, // reg addr
    input wire logic reg_rd_i, // reg read
    input wire logic reg_wr_i, // reg write
    input wire logic [7:0] reg_wdata_i, // reg write data
    input wire logic sfr_wr_o, // special write
    input wire logic [7:0] sfr_wdata_o, // special data
    input wire logic redirect_o, // redirect pulse
    input wire logic [1:0] redirect_ch_o, // redirect channel
    input wire logic [7:0] reg_rdata_o, // reg data
    input wire logic [11:0] daddr_o, // data addr
    input wire logic rdata_valid_o, // valid
    input wire logic sfr_sel_o, // special hit
    input wire logic [3:0] bank_ptr_o // bank
);
    import dmbam_pkg::*;
    wire acc = (rd_i | wr_i) & ~access_sel_i & ~full_move_i;
    wire rreg = reg_rd_i & ~rd_i & ~wr_i;
    wire rwr = reg_wr_i & ~rd_i & ~wr_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    lo_window_a: assert property (acc && !extended_instruction_enable_i && file_addr_i < 8'h60
        |=> daddr_o == {4'h0, $past(file_addr_i)}) else $error("low window address wrong");
    hi_window_a: assert property (acc && file_addr_i >= 8'h60
        |=> daddr_o == {4'hF, $past(file_addr_i)}) else $error("high window address wrong");
    banked_addr_a: assert property ((rd_i || wr_i) && access_sel_i && !full_move_i
        |=> daddr_o == {$past(bank_ptr_o), $past(file_addr_i)}) else $error("banked address wrong");
    move_src_a: assert property (full_move_i && rd_i
        |=> daddr_o == $past(move_src_i)) else $error("move source wrong");
    read_one_a: assert property (rd_i |=> rdata_valid_o) else $error("read data late");
    special_hit_a: assert property (acc |=> sfr_sel_o == ($past(file_addr_i) >= 8'h60))
        else $error("special select wrong");
    bank_upper_a: assert property (rreg && reg_addr_i == DMBAM_BANK_PTR_ADDR
        |=> reg_rdata_o == {4'h0, $past(bank_ptr_o)}) else $error("bank pointer read wrong");
    special_zero_a: assert property (rreg && reg_addr_i >= DMBAM_SFR_BASE && reg_addr_i != DMBAM_BANK_PTR_ADDR
        |=> reg_rdata_o == 8'h00) else $error("empty special not zero");
    redirect_hit_a: assert property ((rreg || rwr) && reg_addr_i == DMBAM_IND0_ADDR
        |=> redirect_o && redirect_ch_o == 2'h0 && !sfr_wr_o) else $error("indirect slot not redirected");
    redirect_ch1_a: assert property ((rreg || rwr) && reg_addr_i == 12'hFE5
        |=> redirect_o && redirect_ch_o == 2'h1) else $error("indirect channel wrong");
    special_write_a: assert property (rwr && reg_addr_i == 12'hF40
        |=> sfr_wr_o && sfr_wdata_o == $past(reg_wdata_i)) else $error("special write not passed on");
    cover property (acc ##1 rdata_valid_o);
    cover property (full_move_i && wr_i);
    cover property (rreg && reg_addr_i == DMBAM_BANK_PTR_ADDR);
endmodule : dmbam_properties

// >>> verif/dmbam_top_tb.sv
/* self-checking bench for the address mapper.
 assumes the core model drives operands; register port tasks live here. */
`timescale 1ns/10ps
module dmbam_top_tb;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic extended_instruction_enable_i = 1'b0;
    logic [7:0] ext_base_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [11:0] reg_addr_i = 12'h000;
    logic [11:0] zero_addr [5] = '{12'h800, 12'hDFF, 12'hF40, 12'hFEF, 12'hFE5};
    logic [7:0] file_addr_i, wdata_i, reg_rdata_o, rdata_o, q;
    logic access_sel_i, full_move_i, move_wr_phase_i, rd_i, wr_i;
    logic [11:0] move_src_i, move_dst_i;
    logic [3:0] bank_ptr_o;
    int errors = 0;
    int samples_checked = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    dmbam_top u_dmbam_top (.ref_clk_i, .sys_rst_i, .file_addr_i, .access_sel_i, .full_move_i, .move_src_i,
        .move_dst_i, .move_wr_phase_i, .extended_instruction_enable_i, .ext_base_i, .rd_i, .wr_i, .wdata_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .daddr_o(), .rdata_o, .rdata_valid_o(),
        .sfr_sel_o(), .sfr_wr_o(), .sfr_wdata_o(), .redirect_o(), .redirect_ch_o(), .bank_ptr_o);
    dmbam_core_model u_dmbam_core_model (.ref_clk_i, .rdata_i(rdata_o), .file_addr_o(file_addr_i),
        .access_sel_o(access_sel_i), .full_move_o(full_move_i), .move_src_o(move_src_i), .move_dst_o(move_dst_i),
        .move_wr_phase_o(move_wr_phase_i), .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));
    task automatic chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one register port cycle; read data sampled in the cycle after
    task automatic rg(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge ref_clk_i);
        {reg_wr_i, reg_rd_i} <= {w, ~w};
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        {reg_wr_i, reg_rd_i} <= 2'h0;
        #1 r = reg_rdata_o;
    endtask : rg
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (1000) @(posedge ref_clk_i);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        chk({4'h0, bank_ptr_o}, 8'h00);
        rg(1'b1, 12'hFE0, 8'hFA, q);
        rg(1'b0, 12'hFE0, 8'h00, q);
        chk(q, 8'h0A);
        u_dmbam_core_model.op(3'h2, 8'hE0, 8'hF3, q);
        chk({4'h0, bank_ptr_o}, 8'h03);
        rg(1'b1, 12'h010, 8'hA5, q);
        u_dmbam_core_model.op(3'h3, 8'h10, 8'h5A, q);
        rg(1'b0, 12'h310, 8'h00, q);
        chk(q, 8'h5A);
        u_dmbam_core_model.op(3'h4, 8'h10, 8'h00, q);
        chk(q, 8'hA5);
        u_dmbam_core_model.op(3'h4, 8'hE0, 8'h00, q);
        chk(q, 8'h03);
        foreach (zero_addr[i]) begin
            rg(1'b1, zero_addr[i], 8'h77, q);
            rg(1'b0, zero_addr[i], 8'h00, q);
            chk(q, 8'h00);
        end
        rg(1'b1, 12'h015, 8'hC3, q);
        @(posedge ref_clk_i);
        extended_instruction_enable_i <= 1'b1;
        ext_base_i <= 8'h10;
        u_dmbam_core_model.op(3'h4, 8'h05, 8'h00, q);
        chk(q, 8'hC3);
        rg(1'b1, 12'h123, 8'h6E, q);
        u_dmbam_core_model.mv(12'h123, 12'h7FF);
        rg(1'b0, 12'h7FF, 8'h00, q);
        chk(q, 8'h6E);
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rg(1'b0, 12'h7FF, 8'h00, q);
        chk(q, 8'h6E);
        chk({4'h0, bank_ptr_o}, 8'h00);
        give_verdict();
    end
endmodule : dmbam_top_tb
bind dmbam_top dmbam_properties u_dmbam_properties (.ref_clk_i, .sys_rst_i, .file_addr_i, .access_sel_i,
    .full_move_i, .move_src_i, .extended_instruction_enable_i, .rd_i, .wr_i, .reg_addr_i, .reg_rd_i,
    .reg_wr_i, .reg_wdata_i, .sfr_wr_o, .sfr_wdata_o, .redirect_o, .redirect_ch_o,
    .reg_rdata_o, .daddr_o, .rdata_valid_o, .sfr_sel_o, .bank_ptr_o);

// >>> verilog/dmbam_ram.sv
/*
 General-purpose data RAM of the mapper: one synchronous write port,
 one asynchronous read port. Assumes the caller limits addresses and
 registers the read data itself.
*/
`timescale 1ns/10ps
module dmbam_ram #(
    parameter int DEPTH = 2048,
    parameter int AW = 11,
    parameter int DW = 8
) (
    input wire logic ref_clk_i, // core clock
    input wire logic we_i, // write enable
    input wire logic [AW-1:0] addr_i, // word address
    input wire logic [DW-1:0] wdata_i, // write data
    output logic [DW-1:0] rdata_o // read data, same cycle
);
    logic [DW-1:0] mem [DEPTH];

    // no reset on purpose: contents survive every reset source
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // read ahead of the write, so a collision returns the old byte
    assign rdata_o = mem[addr_i];
endmodule : dmbam_ram

// >>> verilog/dmbam_top.sv
/*
 Data-memory bank address mapper: turns file addresses into 12-bit data
 addresses, holds the bank pointer and the general RAM, decodes the
 special register area. Assumes the core decoder gives access strobes
 and that special registers other than the bank pointer live elsewhere.
*/
// Function
// - access bit 0 uses access map, ignores pointer
// - access bit 1 prepends bank pointer
// - 00h-5Fh to bank 0, rest to 15
// - access-bank operand done in one cycle
// - full-address move uses embedded 12-bit addresses
// - RAM not reset, kept across resets
// - RAM starts at 000h up to GPR_TOP (7FFh by default)
// - special registers F38h-FFFh decoded there
// - unimplemented special locations read zero
// - indirect locations redirect, hold no storage
// - extended mode selects modified access map
// - bank pointer upper nibble reads zero
// - unimplemented banks discard writes, read zero
`timescale 1ns/10ps
module dmbam_top
    import dmbam_pkg::*;
#(
    parameter int RAM_DEPTH = 2048,
    parameter logic [11:0] GPR_TOP = dmbam_pkg::DMBAM_GPR_TOP_DFLT
) (
    input wire logic ref_clk_i, // 25 MHz core clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic [7:0] file_addr_i, // opcode file address
    input wire logic access_sel_i, // 1 = bank pointer, 0 = access bank
    input wire logic full_move_i, // full-address move in progress
    input wire logic [11:0] move_src_i, // move source address
    input wire logic [11:0] move_dst_i, // move destination address
    input wire logic move_wr_phase_i, // 1 = move destination beat
    input wire logic extended_instruction_enable_i, // extended set enabled
    input wire logic [7:0] ext_base_i, // base for extended access map
    input wire logic rd_i, // operand read strobe
    input wire logic wr_i, // operand write strobe
    input wire logic [7:0] wdata_i, // operand write data
    input wire logic [11:0] reg_addr_i, // register port address
    input wire logic [7:0] reg_wdata_i, // register port write data
    input wire logic reg_wr_i, // register port write strobe
    input wire logic reg_rd_i, // register port read strobe
    output logic [7:0] reg_rdata_o, // register port read data
    output logic [11:0] daddr_o, // registered last data address
    output logic [7:0] rdata_o, // operand read data
    output logic rdata_valid_o, // operand read data valid
    output logic sfr_sel_o, // special area access, registered
    output logic sfr_wr_o, // special register write pulse
    output logic [7:0] sfr_wdata_o, // special register write data
    output logic redirect_o, // indirect location hit, pulse
    output logic [1:0] redirect_ch_o, // indirect channel
    output logic [3:0] bank_ptr_o // current bank
);
    import dmbam_pkg::*;

    localparam int RAW = $clog2(RAM_DEPTH);

    typedef enum logic [1:0] {
        DMBAM_RD_NONE,
        DMBAM_RD_RAM,
        DMBAM_RD_REG,
        DMBAM_RD_ZERO
    } dmbam_rsrc_t;

    logic [3:0] bank_pointer_r;
    logic [11:0] daddr_nxt;
    logic [11:0] op_addr;
    logic [11:0] mux_addr;
    logic mux_wr;
    logic mux_rd;
    logic [7:0] mux_wdata;
    logic in_sfr;
    logic in_gpr;
    logic is_ind;
    logic [1:0] ind_ch;
    logic ram_we;
    logic [7:0] ram_rdata;
    dmbam_rsrc_t rsrc_nxt;
    logic rd_port_nxt;
    logic [7:0] rd_word_nxt;
    logic is_bank_ptr;
    logic any_access;
    logic sfr_wr_nxt;

    // access bank: low part from bank 0, upper part from bank 15
    function automatic logic [11:0] access_map(input logic [7:0] fa);
        if (fa < DMBAM_ACC_SPLIT) begin
            access_map = {DMBAM_ACC_LO_BANK, fa};
        end else begin
            access_map = {DMBAM_ACC_HI_BANK, fa};
        end
    endfunction : access_map

    function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // operand address, purely combinational so the access is single-cycle
    always_comb begin
        op_addr = access_map(file_addr_i);
        if (full_move_i) begin
            op_addr = move_wr_phase_i ? move_dst_i : move_src_i;
        end else if (access_sel_i) begin
            op_addr = {bank_pointer_r, file_addr_i};
        end else if (extended_instruction_enable_i && file_addr_i < DMBAM_ACC_SPLIT) begin
            // modified map: low window indexes off the supplied base
            op_addr = {DMBAM_ACC_LO_BANK, 8'(ext_base_i + file_addr_i)};
        end
    end

    // operand access has priority; register port only when core idle
    always_comb begin
        if (rd_i || wr_i) begin
            mux_addr = op_addr;
            mux_wr = wr_i;
            mux_rd = rd_i;
            mux_wdata = wdata_i;
        end else begin
            mux_addr = reg_addr_i;
            mux_wr = reg_wr_i;
            mux_rd = reg_rd_i;
            mux_wdata = reg_wdata_i;
        end
    end

    assign daddr_nxt = mux_addr;
    assign any_access = mux_rd || mux_wr;

    // only the bank pointer is stored here; other special registers sit outside
    assign is_bank_ptr = (mux_addr == DMBAM_BANK_PTR_ADDR);

    always_comb begin
        in_sfr = in_range(mux_addr, DMBAM_SFR_BASE, DMBAM_SFR_TOP);
        in_gpr = in_range(mux_addr, DMBAM_GPR_BASE, GPR_TOP) && !in_sfr;
        is_ind = 1'b1;
        ind_ch = 2'h0;
        if (in_range(mux_addr, DMBAM_IND0_LAST, DMBAM_IND0_ADDR)) begin
            ind_ch = 2'h0;
        end else if (in_range(mux_addr, DMBAM_IND1_LAST, DMBAM_IND1_ADDR)) begin
            ind_ch = 2'h1;
        end else if (in_range(mux_addr, DMBAM_IND2_LAST, DMBAM_IND2_ADDR)) begin
            ind_ch = 2'h2;
        end else begin
            is_ind = 1'b0;
        end
    end

    // writes outside implemented RAM never reach storage
    assign ram_we = mux_wr && in_gpr;

    dmbam_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(RAW),
        .DW(DMBAM_DATA_W)
    ) u_ram (
        .ref_clk_i(ref_clk_i),
        .we_i(ram_we),
        .addr_i(mux_addr[RAW-1:0]),
        .wdata_i(mux_wdata),
        .rdata_o(ram_rdata)
    );

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bank_pointer_r <= DMBAM_BANK_PTR_RST[3:0];
        end else if (mux_wr && is_bank_ptr) begin
            // upper nibble has no storage, so writes to it vanish
            bank_pointer_r <= mux_wdata[3:0];
        end
    end

    // read source chosen in the request cycle
    always_comb begin
        rsrc_nxt = DMBAM_RD_NONE;
        if (mux_rd) begin
            if (in_gpr) begin
                rsrc_nxt = DMBAM_RD_RAM;
            end else if (in_sfr && is_bank_ptr) begin
                rsrc_nxt = DMBAM_RD_REG;
            end else begin
                rsrc_nxt = DMBAM_RD_ZERO;
            end
        end
    end

    // register port answers only in cycles it owned
    assign rd_port_nxt = !(rd_i || wr_i) && reg_rd_i;

    // RAM reads combinationally so the answer flops keep the one-cycle latency
    always_comb begin
        rd_word_nxt = DMBAM_ZERO;
        unique case (rsrc_nxt)
            DMBAM_RD_NONE: rd_word_nxt = DMBAM_ZERO;
            DMBAM_RD_RAM: rd_word_nxt = ram_rdata;
            DMBAM_RD_REG: rd_word_nxt = {4'h0, bank_pointer_r};
            DMBAM_RD_ZERO: rd_word_nxt = DMBAM_ZERO;
        endcase
    end

    // indirect slots are not stored, pass as redirect instead
    assign sfr_wr_nxt = mux_wr && in_sfr && !is_ind && !is_bank_ptr;

    // operand read data
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= DMBAM_ZERO;
        end else begin
            rdata_o <= rd_port_nxt ? DMBAM_ZERO : rd_word_nxt;
        end
    end

    // operand read valid, one cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= (rsrc_nxt != DMBAM_RD_NONE) && !rd_port_nxt;
        end
    end

    // register port read data, zero outside its answer cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= DMBAM_ZERO;
        end else begin
            reg_rdata_o <= rd_port_nxt ? rd_word_nxt : DMBAM_ZERO;
        end
    end

    // last data address, for tracing the core's accesses
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            daddr_o <= 12'h000;
        end else begin
            daddr_o <= daddr_nxt;
        end
    end

    // special area hit, read or write
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_sel_o <= 1'b0;
        end else begin
            sfr_sel_o <= any_access && in_sfr;
        end
    end

    // write pulse towards the external special registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_wr_o <= 1'b0;
        end else begin
            sfr_wr_o <= sfr_wr_nxt;
        end
    end

    // data held from the last special write, so the bus does not toggle idly
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_wdata_o <= DMBAM_ZERO;
        end else if (sfr_wr_nxt) begin
            sfr_wdata_o <= mux_wdata;
        end
    end

    // redirect pulse for indirect slots
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            redirect_o <= 1'b0;
        end else begin
            redirect_o <= any_access && is_ind;
        end
    end

    // channel of the last redirect, valid beside its pulse
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            redirect_ch_o <= 2'h0;
        end else if (any_access && is_ind) begin
            redirect_ch_o <= ind_ch;
        end
    end

    assign bank_ptr_o = bank_pointer_r;
endmodule : dmbam_top
